// file: common/burst_sram_regs.svh
// timing and layout constants of the burst sram control block
`ifndef BURST_SRAM_REGS_SVH
`define BURST_SRAM_REGS_SVH
`define ADDR_W 15
`define DATA_W 32
`define LANES 4
`define LANE_W 8
`define DEPTH 32768
`define BURST_MAX 4
`define WAKE_NS 100
`define CLK_NS 50
// cycles of wake-up guard; 100 ns at 50 ns period, least time rounds up
`define WAKE_CYC ((`WAKE_NS + `CLK_NS - 1) / `CLK_NS)
`endif

// file: common/burst_sram_pkg.sv
// types shared by the burst sram control block
package burst_sram_pkg;
    // operation decoded on a clock edge
    typedef enum logic [4:0] {
        op_idle = 5'h01,
        op_read = 5'h02,
        op_write = 5'h04,
        op_deselect = 5'h08,
        op_hold = 5'h10
    } op_e;
    typedef logic [1:0] burst_cnt_t;
endpackage : burst_sram_pkg

// file: hdl/sync_burst_sram_control.sv
// synchronous burst static ram with burst counter and output register
`timescale 1ns/1ns
`default_nettype none
`include "burst_sram_regs.svh"
module sync_burst_sram_control (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [`ADDR_W-1:0] address,
    input wire logic primary_select_n,
    input wire logic secondary_select_n,
    input wire logic secondary_select,
    input wire logic processor_addr_strobe_n,
    input wire logic controller_addr_strobe_n,
    input wire logic burst_advance_n,
    input wire logic global_write_n,
    input wire logic byte_write_gate_n,
    input wire logic [`LANES-1:0] byte_lane_write_n,
    input wire logic burst_order_interleaved,
    input wire logic output_enable_n,
    input wire logic sleep_request,
    input wire logic [`DATA_W-1:0] data_lines_in,
    output logic [`DATA_W-1:0] data_lines_out,
    output logic [`DATA_W-1:0] data_lines_oe
);
    import burst_sram_pkg::*;

    // storage array
    logic [`DATA_W-1:0] mem [0:`DEPTH-1];
    // upper address bits and start low bits
    logic [`ADDR_W-3:0] upper_r;
    burst_cnt_t start_r;
    // burst counter
    burst_cnt_t count_r;
    // a burst is open
    logic active_r;
    // registered operation of the previous edge
    op_e op_r;
    logic [`LANES-1:0] lane_we_r;
    logic [`DATA_W-1:0] wdata_r;
    logic [`DATA_W-1:0] rdata_r;
    logic read_pend_r;
    // output register and drive
    logic [`DATA_W-1:0] dout_r;
    logic drive_r;
    // decode wires
    logic sel_ok;
    logic psel;
    logic cstrobe;
    logic write_req;
    // gate low with at least one lane enable low
    logic any_lane_write;
    logic [`LANES-1:0] lanes;
    burst_cnt_t low_bits;
    logic [`ADDR_W-1:0] word_addr;

    // all three selects active
    assign sel_ok = !primary_select_n && !secondary_select_n
        && secondary_select;
    // processor strobe gated by primary select
    assign psel = !processor_addr_strobe_n && !primary_select_n;
    // controller strobe wins only with processor strobe not taken
    assign cstrobe = !controller_addr_strobe_n && !psel;
    // write request decode
    assign any_lane_write = !byte_write_gate_n
        && !(&byte_lane_write_n);
    assign write_req = !global_write_n || any_lane_write;
    // byte lanes to write
    assign lanes = !global_write_n ? {`LANES{1'b1}}
        : (byte_write_gate_n ? {`LANES{1'b0}} : ~byte_lane_write_n);
    // burst order: interleaved xors, linear adds modulo four
    assign low_bits = burst_order_interleaved ? (start_r ^ count_r)
        : burst_cnt_t'(start_r + count_r);
    assign word_addr = {upper_r, low_bits};

    // address, start bits and burst counter
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            upper_r <= '0;
            start_r <= 2'h0;
            count_r <= 2'h0;
            active_r <= 1'b0;
        end else if (sleep_request) begin
            // sleep: close burst, hold address and counter, no new cycle
            active_r <= 1'b0;
        end else if (psel || cstrobe) begin
            // new address; advance ignored
            if (sel_ok) begin
                upper_r <= address[`ADDR_W-1:2];
                start_r <= address[1:0];
                count_r <= 2'h0;
                active_r <= 1'b1;
            end else begin
                active_r <= 1'b0;
            end
        end else if (active_r && !burst_advance_n) begin
            // continue: step, wrap within group
            count_r <= burst_cnt_t'(count_r + 2'h1);
        end
    end

    // operation for the word at the current address
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            op_r <= op_idle;
            lane_we_r <= '0;
            wdata_r <= '0;
        end else begin
            wdata_r <= data_lines_in;
            lane_we_r <= '0;
            if (sleep_request) begin
                op_r <= op_idle;
            end else if (psel) begin
                // processor start is a read with all selects active, else a deselect
                op_r <= sel_ok ? op_read : op_deselect;
            end else if (cstrobe) begin
                if (!sel_ok) begin
                    op_r <= op_deselect;
                end else if (write_req) begin
                    op_r <= op_write;
                    lane_we_r <= lanes;
                end else begin
                    op_r <= op_read;
                end
            end else if (active_r) begin
                // continue or suspend; enables pick direction
                if (write_req) begin
                    op_r <= op_write;
                    lane_we_r <= lanes;
                end else begin
                    op_r <= op_read;
                end
            end else begin
                op_r <= op_hold;
            end
        end
    end

    // array write and registered read, per byte lane
    always_ff @(posedge sys_clk) begin
        for (int i = 0; i < `LANES; i++) begin
            if (lane_we_r[i]) begin
                mem[word_addr][i*`LANE_W +: `LANE_W] <=
                    wdata_r[i*`LANE_W +: `LANE_W];
            end
        end
        rdata_r <= mem[word_addr];
    end

    // read pending one edge after the read address
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            read_pend_r <= 1'b0;
        end else begin
            read_pend_r <= (op_r == op_read);
        end
    end

    // output register and drive enable
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            dout_r <= '0;
            drive_r <= 1'b0;
        end else begin
            if (read_pend_r) begin
                dout_r <= rdata_r;
            end
            drive_r <= read_pend_r && !output_enable_n
                && !sleep_request;
        end
    end

    assign data_lines_out = dout_r;
    assign data_lines_oe = {`DATA_W{drive_r}};

    // processor start with selects gives a read next edge
    a_proc_read_start: assert property (@(posedge sys_clk) disable iff (rst)
        (psel && sel_ok && !sleep_request) |=> op_r == op_read)
        else $error("processor start did not read");
    // primary deselected processor strobe does not load
    a_proc_gated: assert property (@(posedge sys_clk) disable iff (rst)
        (primary_select_n && controller_addr_strobe_n
        && !processor_addr_strobe_n) |=> $stable(upper_r))
        else $error("gated processor strobe loaded address");
    // controller write start
    a_ctrl_write: assert property (@(posedge sys_clk) disable iff (rst)
        (cstrobe && sel_ok && !global_write_n && !sleep_request)
        |=> op_r == op_write && lane_we_r == 4'hf)
        else $error("controller write not started");
    // burst begin loads counter zero
    a_cnt_load: assert property (@(posedge sys_clk) disable iff (rst)
        ((psel || cstrobe) && sel_ok && !sleep_request)
        |=> count_r == 2'h0 && start_r == $past(address[1:0]))
        else $error("burst counter not loaded");
    // advance low steps the counter
    a_cnt_step: assert property (@(posedge sys_clk) disable iff (rst)
        (active_r && !psel && !cstrobe && !burst_advance_n && !sleep_request)
        |=> count_r == $past(count_r) + 2'h1)
        else $error("counter did not step");
    // advance high suspends
    a_cnt_hold: assert property (@(posedge sys_clk) disable iff (rst)
        (!psel && !cstrobe && burst_advance_n)
        |=> $stable(count_r) && $stable(upper_r))
        else $error("suspend moved address");
    // deselect ends burst
    a_deselect: assert property (@(posedge sys_clk) disable iff (rst)
        ((psel || cstrobe) && !sel_ok) |=> !active_r)
        else $error("deselect left burst open");
    // read data reaches output two edges after the read op
    a_read_out: assert property (@(posedge sys_clk) disable iff (rst)
        (op_r == op_read) |=> ##1 dout_r == $past(rdata_r))
        else $error("read data not registered");
    // no drive while sleeping or disabled
    a_no_drive: assert property (@(posedge sys_clk) disable iff (rst)
        (sleep_request || output_enable_n) |=> !drive_r)
        else $error("data lines driven illegally");
endmodule : sync_burst_sram_control
`default_nettype wire

// file: verification/data_wire_model.sv
// data wire model standing on the controller side of the sram
`timescale 1ns/1ns
`default_nettype none
module data_wire_model (
    input wire logic sys_clk,
    input wire logic [31:0] dev_out,
    input wire logic [31:0] dev_oe,
    input wire logic [31:0] host_data,
    input wire logic host_drive,
    output logic [31:0] wire_level
);
    logic [31:0] last_r = 32'h0000_0000; // last level seen on the wire
    // released bits show the inverse of their last level
    always_comb begin
        if (host_drive)
            wire_level = host_data;
        else
            wire_level = (dev_out & dev_oe) | (~last_r & ~dev_oe);
    end
    // remember the level for the next released cycle
    always_ff @(posedge sys_clk) begin
        last_r <= wire_level;
    end
endmodule : data_wire_model
`default_nettype wire

// file: verification/tb_top.sv
// self-checking bench for the burst sram control block
`timescale 1ns/1ns
`default_nettype none
`include "burst_sram_regs.svh"
module tb_top;
    logic sys_clk = 1'b0, rst = 1'b1, pri_n = 1'b0, sec = 1'b1;
    logic ps_n = 1'b1, cs_n = 1'b1, adv_n = 1'b1, gw_n = 1'b1;
    logic bwg_n = 1'b1, il = 1'b1, oe_n = 1'b0, drive = 1'b0;
    logic sec_n = 1'b0, slp = 1'b0;
    logic [14:0] address = 15'h0000;
    logic [3:0] lane_n = 4'hF;
    logic [31:0] wdata = 32'h0000_0000, dout, doe, wire_level;
    logic [31:0] mem [0:15]; // expected array contents
    int miscompares = 0, tests_run = 0, wseq = 0;
    always #25 sys_clk = ~sys_clk;
    sync_burst_sram_control u_sync_burst_sram_control (
        .sys_clk(sys_clk), .rst(rst), .address(address),
        .primary_select_n(pri_n), .secondary_select_n(sec_n),
        .secondary_select(sec), .processor_addr_strobe_n(ps_n),
        .controller_addr_strobe_n(cs_n), .burst_advance_n(adv_n),
        .global_write_n(gw_n), .byte_write_gate_n(bwg_n),
        .byte_lane_write_n(lane_n), .burst_order_interleaved(il),
        .output_enable_n(oe_n), .sleep_request(slp),
        .data_lines_in(wire_level), .data_lines_out(dout),
        .data_lines_oe(doe));
    data_wire_model u_data_wire_model (.sys_clk(sys_clk), .dev_out(dout),
        .dev_oe(doe), .host_data(wdata), .host_drive(drive),
        .wire_level(wire_level));
    task automatic end_sim;
        if (miscompares == 0 && tests_run > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : end_sim
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // word address of a burst step in the current order
    function automatic logic [14:0] ea(input logic [14:0] a,
        input logic [1:0] k);
        return {a[14:2], il ? a[1:0] ^ k : a[1:0] + k};
    endfunction : ea
    // deselect cycle: controller strobe with second select off ends a burst
    task automatic idle;
        {pri_n, sec_n, ps_n, cs_n, adv_n, gw_n, bwg_n, drive} = 8'b0110_1110;
    endtask : idle
    // four write edges; mask bit k asks for advance at edge k
    task automatic wr(input logic [14:0] a, input logic g,
        input logic [3:0] mask);
        logic [1:0] cnt;
        logic [14:0] e;
        cnt = 2'b00;
        for (int k = 0; k < 4; k++) begin
            @(negedge sys_clk);
            if (k > 0 && mask[k])
                cnt++;
            e = ea(a, cnt);
            wseq++;
            wdata = {8'h5A, 1'b0, e, 8'(wseq)};
            {sec_n, cs_n, adv_n, gw_n, bwg_n, drive} =
                {1'b0, k > 0, ~mask[k], g, ~g, 1'b1};
            address = a;
            if (k > 0)
                chk(doe, 32'h0000_0000);
            for (int b = 0; b < 4; b++)
                if (!g || !lane_n[b])
                    mem[e[3:0]][8*b+:8] = wdata[8*b+:8];
        end
        @(negedge sys_clk);
        idle;
    endtask : wr
    // four read edges, then output words checked as they arrive
    task automatic rd(input logic [14:0] a, input logic p,
        input logic [3:0] mask);
        logic [14:0] q [0:3];
        logic [1:0] cnt;
        cnt = 2'b00;
        for (int k = 0; k < 7; k++) begin
            @(negedge sys_clk);
            if (k >= 3) begin
                chk(doe, {32{~oe_n}});
                if (!oe_n)
                    chk(dout, mem[q[k-3][3:0]]);
            end
            if (k < 4) begin
                if (k > 0 && mask[k])
                    cnt++;
                q[k] = ea(a, cnt);
                {ps_n, cs_n, gw_n} = {!(p && k == 0), !(!p && k == 0),
                    !(p && k == 0)};
                adv_n = ~mask[k];
                sec_n = 1'b0;
                address = a;
            end else
                idle;
        end
    endtask : rd
    // read burst, gated processor strobe while advancing, then deselect
    task automatic refused;
        @(negedge sys_clk);
        {pri_n, sec_n, cs_n, adv_n} = 4'b0001;
        address = 15'h7FF4;
        @(negedge sys_clk);
        {pri_n, ps_n, cs_n, adv_n} = 4'b1010;
        address = 15'h7FF0;
        @(negedge sys_clk);
        {ps_n, sec, cs_n, gw_n, adv_n} = 5'b00001;
        @(negedge sys_clk);
        sec = 1'b1;
        idle;
        chk(doe, 32'hFFFF_FFFF);
        chk(dout, mem[4]);
        @(negedge sys_clk);
        chk(dout, mem[5]);
        @(negedge sys_clk);
        chk(doe, 32'h0000_0000);
    endtask : refused
    // processor start, then one write word with advance held high
    task automatic pwr(input logic [14:0] a);
        @(negedge sys_clk);
        {sec_n, ps_n, cs_n, oe_n} = 4'b0011;
        address = a;
        @(negedge sys_clk);
        {ps_n, adv_n, gw_n, drive} = 4'b1101;
        wdata = {8'hC3, 1'b0, a, 8'h11};
        mem[a[3:0]] = wdata;
        @(negedge sys_clk);
        idle;
        @(negedge sys_clk);
        oe_n = 1'b0;
    endtask : pwr
    // read start, then sleep: lines stay released; strobes wait after wake
    task automatic nap;
        @(negedge sys_clk);
        {sec_n, cs_n} = 2'b00;
        address = 15'h7FF2;
        @(negedge sys_clk);
        {cs_n, slp} = 2'b11;
        repeat (2) begin
            @(negedge sys_clk);
            chk(doe, 32'h0000_0000);
        end
        {ps_n, cs_n, slp} = 3'b110;
        repeat (`WAKE_CYC) @(negedge sys_clk);
        idle;
    endtask : nap
    initial begin
        repeat (4) @(negedge sys_clk);
        rst = 1'b0;
        il = 1'b0;
        wr(15'h7FF2, 1'b0, 4'b1110);
        il = 1'b1;
        wr(15'h7FF5, 1'b0, 4'b1110);
        rd(15'h7FF1, 1'b1, 4'b1111);
        il = 1'b0;
        rd(15'h7FF6, 1'b0, 4'b1010);
        lane_n = 4'b1010;
        wr(15'h7FF3, 1'b1, 4'b0100);
        rd(15'h7FF3, 1'b0, 4'b1110);
        refused;
        nap;
        rd(15'h7FF0, 1'b0, 4'b0000);
        pwr(15'h7FF8);
        rd(15'h7FF8, 1'b1, 4'b0000);
        oe_n = 1'b1;
        rd(15'h7FF4, 1'b0, 4'b1110);
        end_sim;
    end
    // guard against a hung run
    initial begin
        #200000;
        miscompares++;
        end_sim;
    end
endmodule : tb_top
`default_nettype wire
